// ==== core/io_switch_matrix.sv ====
`timescale 1ns/1ns
// Camera I/O switch matrix with persistent slot storage
module io_switch_matrix
    import io_switch_pkg::*;
#(
    parameter int OD_PRESENT = NUM_OD // Open-drain pins fitted on this model
)(
    input wire logic core_clk, // 250 MHz system clock
    input wire logic srst, // Sync reset, active high
    // Sources
    input wire logic [3:0] trig_in, // External trigger pins
    input wire logic ser_rxd, // Serial receive pin
    input wire logic uart1_txd, // UART1 transmit
    input wire logic [NUM_PLOOP-1:0] ploop_strobe, // Pulse-loop strobes
    input wire logic seq_pwm_out_first, // Sequencer PWM A
    input wire logic seq_pwm_out_b, // Sequencer PWM B
    input wire logic seq_pwm_out_c, // Sequencer PWM C
    input wire logic seq_pwm_out_d, // Sequencer PWM D
    input wire logic seq_pulse, // Sequencer pulse
    input wire logic seq_pwm_mask, // Sequencer PWM-mask pulse
    input wire logic seq_active, // Sequencer active flag
    input wire logic expose_stat, // Exposure in progress
    input wire logic readout_stat, // Readout in progress
    input wire logic debounce_out, // Debouncer result
    input wire logic prescale_out, // Prescaler result
    input wire logic lens_rxd, // Lens receive line
    input wire logic trig_feedback, // Trigger feedback
    input wire logic uart2_txd, // UART2 transmit
    // Destinations
    output logic [NUM_OD-1:0] od_out_o, // Open-drain output level (always 0)
    output logic [NUM_OD-1:0] od_out_oe, // Open-drain enable, high pulls low
    output logic ser_txd, // Serial transmit pin
    output logic uart1_rxd, // UART1 receive
    output logic cam_trigger, // Camera trigger
    output logic seq_hw_start, // Sequencer hardware start
    output logic debounce_in, // Debouncer input
    output logic prescale_in, // Prescaler input
    output logic lens_txd, // Lens transmit line
    output logic [NUM_PLOOP-1:0] ploop_hw_trig, // Pulse-loop triggers
    output logic uart2_rxd, // UART2 receive
    // Configuration port
    input wire logic cfg_wr, // Write one line config
    input wire logic [SEL_W-1:0] cfg_dst, // Destination to write/read
    input wire logic [CFG_W-1:0] cfg_wdata, // {force, invert, select}
    output logic [CFG_W-1:0] cfg_rdata, // Live config of cfg_dst
    input wire logic [1:0] logic_op, // Logic gate operation
    input wire logic [SLOT_W-1:0] config_slot_select, // Slot chosen for load/store
    input wire logic config_slot_load, // Pulse: load chosen slot into live
    input wire logic config_slot_store, // Pulse: store live into chosen slot
    input wire logic config_factory_load, // Pulse: restore factory routing
    output logic cfg_busy // Slot copy in progress
);
    typedef enum {ST_IDLE, ST_LOAD, ST_STORE} copy_state_t;

    logic [CFG_W-1:0] live_cfg_r [NUM_DST];
    logic [CFG_W-1:0] slot_mem [NUM_SLOTS * NUM_DST];
    logic [NUM_DST-1:0] dst_line;
    logic [NUM_SRC-1:0] src_vec;
    logic logic_res_r;
    logic logic_res_nxt;
    copy_state_t state_r;
    logic [SEL_W-1:0] idx_r;
    logic [SLOT_W-1:0] slot_r;
    logic [CFG_W-1:0] mem_rd_r;
    logic mem_rd_vld_r;

    // Source vector assembly
    always_comb begin
        src_vec = '0;
        src_vec[SRC_TRIG_IN0 +: 4] = trig_in;
        src_vec[SRC_SER_RX] = ser_rxd;
        src_vec[SRC_UART1_TX] = uart1_txd;
        src_vec[SRC_STROBE0] = ploop_strobe[0];
        src_vec[SRC_STROBE1] = ploop_strobe[1];
        src_vec[SRC_STROBE2] = ploop_strobe[2];
        src_vec[SRC_STROBE3] = ploop_strobe[3];
        src_vec[SRC_SEQ_PWM_A] = seq_pwm_out_first;
        src_vec[SRC_SEQ_PWM_B] = seq_pwm_out_b;
        src_vec[SRC_SEQ_PWM_C] = seq_pwm_out_c;
        src_vec[SRC_SEQ_PWM_D] = seq_pwm_out_d;
        src_vec[SRC_SEQ_PULSE] = seq_pulse;
        src_vec[SRC_SEQ_MASK] = seq_pwm_mask;
        src_vec[SRC_SEQ_ACTIVE] = seq_active;
        src_vec[SRC_EXPOSE] = expose_stat;
        src_vec[SRC_READOUT] = readout_stat;
        src_vec[SRC_DEBOUNCE] = debounce_out;
        src_vec[SRC_PRESCALE] = prescale_out;
        src_vec[SRC_LOGIC] = logic_res_r;
        src_vec[SRC_LENS_RX] = lens_rxd;
        src_vec[SRC_TRIG_FB] = trig_feedback;
        src_vec[SRC_UART2_TX] = uart2_txd;
    end

    // One registered line per destination
    for (genvar d = 0; d < NUM_DST; d++) begin : g_line
        io_switch_line u_line (
            .core_clk(core_clk),
            .srst(srst),
            .src_vec(src_vec),
            .cfg(live_cfg_r[d]),
            .line_out_r(dst_line[d])
        );
    end

    // Logic module combines destinations 10 and 11
    always_comb begin
        case (logic_op_t'(logic_op))
            LOGIC_AND: logic_res_nxt = dst_line[DST_LOGIC_A] & dst_line[DST_LOGIC_B];
            LOGIC_OR: logic_res_nxt = dst_line[DST_LOGIC_A] | dst_line[DST_LOGIC_B];
            LOGIC_XOR: logic_res_nxt = dst_line[DST_LOGIC_A] ^ dst_line[DST_LOGIC_B];
            LOGIC_NAND: logic_res_nxt = ~(dst_line[DST_LOGIC_A] & dst_line[DST_LOGIC_B]);
            default: logic_res_nxt = 1'b0;
        endcase
    end

    // Registered so the feedback path never forms a combinational loop
    always_ff @(posedge core_clk) begin
        if (srst) begin
            logic_res_r <= 1'b0;
        end else begin
            logic_res_r <= logic_res_nxt;
        end
    end

    // Output registers; absent open-drain pins stay released
    always_ff @(posedge core_clk) begin
        if (srst) begin
            od_out_oe <= '0;
            ser_txd <= 1'b0;
            uart1_rxd <= 1'b0;
            cam_trigger <= 1'b0;
            seq_hw_start <= 1'b0;
            debounce_in <= 1'b0;
            prescale_in <= 1'b0;
            lens_txd <= 1'b0;
            ploop_hw_trig <= '0;
            uart2_rxd <= 1'b0;
        end else begin
            for (int i = 0; i < NUM_OD; i++) begin
                od_out_oe[i] <= (i < OD_PRESENT) && !dst_line[DST_OD0 + i];
            end
            ser_txd <= dst_line[DST_SER_TX];
            uart1_rxd <= dst_line[DST_UART1_RX];
            cam_trigger <= dst_line[DST_CAM_TRIG];
            seq_hw_start <= dst_line[DST_SEQ_START];
            debounce_in <= dst_line[DST_DEBOUNCE];
            prescale_in <= dst_line[DST_PRESCALE];
            lens_txd <= dst_line[DST_LENS_TX];
            ploop_hw_trig <= dst_line[DST_PLOOP0 +: NUM_PLOOP];
            uart2_rxd <= dst_line[DST_UART2_RX];
        end
    end

    // Open drain only ever pulls low
    always_ff @(posedge core_clk) begin
        od_out_o <= '0;
    end

    // Slot copy sequencer; one line per cycle, commands ignored while busy
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_r <= ST_IDLE;
            idx_r <= '0;
            slot_r <= '0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    idx_r <= '0;
                    slot_r <= config_slot_select;
                    if (config_slot_load) begin
                        state_r <= ST_LOAD;
                    end else if (config_slot_store) begin
                        state_r <= ST_STORE;
                    end
                end
                ST_LOAD: begin
                    // Memory read lags one cycle, so run one extra step
                    if (idx_r == SEL_W'(NUM_DST)) begin
                        state_r <= ST_IDLE;
                    end
                    idx_r <= idx_r + 1'b1;
                end
                ST_STORE: begin
                    if (idx_r == SEL_W'(NUM_DST - 1)) begin
                        state_r <= ST_IDLE;
                    end
                    idx_r <= idx_r + 1'b1;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Persistent slot array, synchronous read and write
    always_ff @(posedge core_clk) begin
        mem_rd_r <= slot_mem[slot_r * NUM_DST + (idx_r < SEL_W'(NUM_DST) ? idx_r : '0)];
        if (state_r == ST_STORE) begin
            slot_mem[slot_r * NUM_DST + idx_r] <= live_cfg_r[idx_r];
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            mem_rd_vld_r <= 1'b0;
        end else begin
            mem_rd_vld_r <= (state_r == ST_LOAD) && (idx_r < SEL_W'(NUM_DST));
        end
    end

    // Live configuration: factory restore beats slot load beats port write
    always_ff @(posedge core_clk) begin
        if (srst) begin
            for (int d = 0; d < NUM_DST; d++) begin
                live_cfg_r[d] <= DEFAULT_CFG;
            end
        end else if (config_factory_load && state_r == ST_IDLE) begin
            for (int d = 0; d < NUM_DST; d++) begin
                live_cfg_r[d] <= DEFAULT_CFG;
            end
        end else if (mem_rd_vld_r) begin
            live_cfg_r[idx_r - 1'b1] <= mem_rd_r;
        end else if (cfg_wr && state_r == ST_IDLE && cfg_dst < SEL_W'(NUM_DST)) begin
            live_cfg_r[cfg_dst] <= cfg_wdata;
        end
    end

    // Readback and busy status
    always_ff @(posedge core_clk) begin
        if (srst) begin
            cfg_rdata <= '0;
            cfg_busy <= 1'b0;
        end else begin
            cfg_rdata <= (cfg_dst < SEL_W'(NUM_DST)) ? live_cfg_r[cfg_dst] : '0;
            cfg_busy <= (state_r != ST_IDLE) || config_slot_load || config_slot_store;
        end
    end
endmodule : io_switch_matrix

// ==== core/io_switch_pkg.sv ====
package io_switch_pkg;
    localparam int NUM_SRC = 25;
    localparam int NUM_DST = 18;
    localparam int SEL_W = 5;
    localparam int NUM_SLOTS = 8;
    localparam int SLOT_W = 3;
    // Per-line word: {force_high, invert, select}
    localparam int CFG_W = SEL_W + 2;
    localparam int INV_BIT = SEL_W;
    localparam int FORCE_BIT = SEL_W + 1;

    // Source indices
    localparam logic [SEL_W-1:0] SRC_TRIG_IN0 = 5'h00;
    localparam logic [SEL_W-1:0] SRC_SER_RX = 5'h04;
    localparam logic [SEL_W-1:0] SRC_UART1_TX = 5'h05;
    localparam logic [SEL_W-1:0] SRC_STROBE0 = 5'h06;
    localparam logic [SEL_W-1:0] SRC_STROBE1 = 5'h07;
    localparam logic [SEL_W-1:0] SRC_SEQ_PWM_A = 5'h08;
    localparam logic [SEL_W-1:0] SRC_SEQ_PWM_B = 5'h09;
    localparam logic [SEL_W-1:0] SRC_EXPOSE = 5'h0a;
    localparam logic [SEL_W-1:0] SRC_READOUT = 5'h0b;
    localparam logic [SEL_W-1:0] SRC_SEQ_PULSE = 5'h0c;
    localparam logic [SEL_W-1:0] SRC_SEQ_PWM_C = 5'h0d;
    localparam logic [SEL_W-1:0] SRC_SEQ_PWM_D = 5'h0e;
    localparam logic [SEL_W-1:0] SRC_SEQ_ACTIVE = 5'h0f;
    localparam logic [SEL_W-1:0] SRC_DEBOUNCE = 5'h10;
    localparam logic [SEL_W-1:0] SRC_PRESCALE = 5'h11;
    localparam logic [SEL_W-1:0] SRC_SEQ_MASK = 5'h12;
    localparam logic [SEL_W-1:0] SRC_LOGIC = 5'h13;
    localparam logic [SEL_W-1:0] SRC_STROBE2 = 5'h14;
    localparam logic [SEL_W-1:0] SRC_STROBE3 = 5'h15;
    localparam logic [SEL_W-1:0] SRC_LENS_RX = 5'h16;
    localparam logic [SEL_W-1:0] SRC_TRIG_FB = 5'h17;
    localparam logic [SEL_W-1:0] SRC_UART2_TX = 5'h18;

    // Destination indices
    localparam int DST_OD0 = 0;
    localparam int NUM_OD = 4;
    localparam int DST_SER_TX = 4;
    localparam int DST_UART1_RX = 5;
    localparam int DST_CAM_TRIG = 6;
    localparam int DST_SEQ_START = 7;
    localparam int DST_DEBOUNCE = 8;
    localparam int DST_PRESCALE = 9;
    localparam int DST_LOGIC_A = 10;
    localparam int DST_LOGIC_B = 11;
    localparam int DST_LENS_TX = 12;
    localparam int DST_PLOOP0 = 13;
    localparam int NUM_PLOOP = 4;
    localparam int DST_UART2_RX = 17;

    // Logic gate operations
    typedef enum logic [1:0] {LOGIC_AND, LOGIC_OR, LOGIC_XOR, LOGIC_NAND} logic_op_t;

    // Factory default: unused lines stay at a harmless source, lines idle low
    localparam logic [SEL_W-1:0] DEFAULT_SEL = 5'h00;
    localparam logic [CFG_W-1:0] DEFAULT_CFG = {2'b00, DEFAULT_SEL};
endpackage : io_switch_pkg

// ==== core/io_switch_line.sv ====
`timescale 1ns/1ns
// One destination line: select, invert, force, registered
module io_switch_line
    import io_switch_pkg::*;
(
    input wire logic core_clk, // System clock
    input wire logic srst, // Sync reset, active high
    input wire logic [NUM_SRC-1:0] src_vec, // All matrix sources
    input wire logic [CFG_W-1:0] cfg, // Live line configuration
    output logic line_out_r // Registered line value
);
    logic sel_bit;
    logic line_nxt;

    // Out-of-range selector reads as low rather than wrapping
    always_comb begin
        sel_bit = 1'b0;
        if (cfg[SEL_W-1:0] < SEL_W'(NUM_SRC)) begin
            sel_bit = src_vec[cfg[SEL_W-1:0]];
        end
        line_nxt = (cfg[FORCE_BIT] | sel_bit) ^ cfg[INV_BIT];
    end

    // Register removes any decode glitch on the pin
    always_ff @(posedge core_clk) begin
        if (srst) begin
            line_out_r <= 1'b0;
        end else begin
            line_out_r <= line_nxt;
        end
    end
endmodule : io_switch_line

// ==== dv/io_switch_props.sv ====
`timescale 1ns/1ns
// Port-level timing and value checks of the matrix
module io_switch_props
    import io_switch_pkg::*;
(
    input wire logic core_clk, // Clock
    input wire logic srst, // Sync reset
    input wire logic [NUM_OD-1:0] od_out_o, // OD level
    input wire logic [NUM_OD-1:0] od_out_oe, // OD enable
    input wire logic cam_trigger, // Line 6
    input wire logic cfg_wr, // Write strobe
    input wire logic [SEL_W-1:0] cfg_dst, // Line index
    input wire logic [CFG_W-1:0] cfg_wdata, // Line word
    input wire logic [CFG_W-1:0] cfg_rdata, // Read back
    input wire logic config_slot_load, // Load pulse
    input wire logic config_slot_store, // Store pulse
    input wire logic config_factory_load, // Factory pulse
    input wire logic cfg_busy // Copy running
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    // Open drain never drives high
    od_level_a: assert property (od_out_o == '0)
        else $error("od level driven high");
    reset_default_a: assert property ($fell(srst) |-> cfg_rdata == DEFAULT_CFG && !cfg_busy && !cam_trigger)
        else $error("state after reset not default");
    // Read back two edges after a taken write
    write_read_a: assert property (cfg_wr && !cfg_busy && cfg_dst < NUM_DST && !config_factory_load
        ##1 $stable(cfg_dst) && !config_factory_load |=> cfg_rdata == $past(cfg_wdata, 2))
        else $error("written line word not read back");
    cam_force_a: assert property (cfg_wr && !cfg_busy && cfg_dst == DST_CAM_TRIG && cfg_wdata[FORCE_BIT]
        && !config_factory_load |-> ##3 cam_trigger == !$past(cfg_wdata[INV_BIT], 3))
        else $error("forced camera trigger wrong");
    od_force_a: assert property (cfg_wr && !cfg_busy && cfg_dst == DST_OD0 && cfg_wdata[FORCE_BIT]
        && !config_factory_load |-> ##3 od_out_oe[0] == $past(cfg_wdata[INV_BIT], 3))
        else $error("forced od line wrong");
    store_busy_a: assert property (config_slot_store && !config_slot_load && !cfg_busy
        |=> cfg_busy [*8] ##[1:20] !cfg_busy)
        else $error("store busy span wrong");
    load_busy_a: assert property (config_slot_load && !cfg_busy |=> cfg_busy [*8] ##[1:20] !cfg_busy)
        else $error("load busy span wrong");
    factory_a: assert property (config_factory_load && !cfg_busy ##1 !cfg_wr |=> cfg_rdata == DEFAULT_CFG)
        else $error("factory routing not restored");
endmodule : io_switch_props

bind io_switch_matrix io_switch_props i_io_switch_props (.core_clk(core_clk), .srst(srst),
    .od_out_o(od_out_o), .od_out_oe(od_out_oe), .cam_trigger(cam_trigger), .cfg_wr(cfg_wr),
    .cfg_dst(cfg_dst), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .config_slot_load(config_slot_load),
    .config_slot_store(config_slot_store), .config_factory_load(config_factory_load), .cfg_busy(cfg_busy));

// ==== dv/io_far_model.sv ====
`timescale 1ns/1ns
// Far side: pins, helper modules and status as plain levels
module io_far_model
    import io_switch_pkg::*;
(
    input wire logic core_clk, // Clock
    input wire logic [NUM_SRC-1:0] src_set, // Levels from bench
    input wire logic [NUM_PLOOP-1:0] ploop_hw_trig, // Triggers from matrix
    input wire logic loop_en, // Strobes follow triggers
    output logic [NUM_SRC-1:0] src // Levels into matrix
);
    logic [NUM_PLOOP-1:0] echo_r;
    // Pulse-loop stand-in: strobe is its trigger one clock late
    always_ff @(posedge core_clk) begin
        echo_r <= ploop_hw_trig;
    end
    // Bit 19 is the matrix's own gate, so its value here is unused
    always_comb begin
        src = src_set;
        if (loop_en) begin
            src[7:6] = echo_r[1:0];
            src[21:20] = echo_r[3:2];
        end
    end
endmodule : io_far_model

// ==== dv/io_switch_matrix_test.sv ====
`timescale 1ns/1ns
// Routing, line options, gate and slot copies
module io_switch_matrix_test
    import io_switch_pkg::*;
;
    // Lines 10 and 11 have no port; seen only through the gate
    localparam logic [17:0] VIS = 18'h3f3ff;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic cfg_wr = 1'b0;
    logic config_slot_load = 1'b0;
    logic config_slot_store = 1'b0;
    logic config_factory_load = 1'b0;
    logic loop_en = 1'b0;
    logic [SEL_W-1:0] cfg_dst = 5'h00;
    logic [CFG_W-1:0] cfg_wdata = 7'h00;
    logic [SLOT_W-1:0] config_slot_select = 3'h0;
    logic [1:0] logic_op = 2'h0;
    logic [NUM_SRC-1:0] src_set = 25'h0000000;
    logic [NUM_SRC-1:0] src;
    logic [NUM_OD-1:0] od_out_o, od_out_oe, ploop_hw_trig;
    logic ser_txd, uart1_rxd, cam_trigger, seq_hw_start, debounce_in, prescale_in, lens_txd, uart2_rxd, cfg_busy;
    logic [CFG_W-1:0] cfg_rdata;
    logic [17:0] dst;
    int n_fail = 0;
    int n_checks = 0;

    // Line view; an enabled open drain means the line is low
    assign dst = {uart2_rxd, ploop_hw_trig, lens_txd, 2'b00, prescale_in, debounce_in, seq_hw_start,
        cam_trigger, uart1_rxd, ser_txd, ~od_out_oe};
    initial forever #2 core_clk = ~core_clk;

    io_far_model i_io_far_model (.core_clk(core_clk), .src_set(src_set), .ploop_hw_trig(ploop_hw_trig),
        .loop_en(loop_en), .src(src));
    // Source numbering of the matrix inputs
    io_switch_matrix i_io_switch_matrix (.core_clk(core_clk), .srst(srst), .trig_in(src[3:0]),
        .ser_rxd(src[4]), .uart1_txd(src[5]), .ploop_strobe({src[21:20], src[7:6]}),
        .seq_pwm_out_first(src[8]), .seq_pwm_out_b(src[9]), .seq_pwm_out_c(src[13]), .seq_pwm_out_d(src[14]),
        .seq_pulse(src[12]), .seq_pwm_mask(src[18]), .seq_active(src[15]), .expose_stat(src[10]),
        .readout_stat(src[11]), .debounce_out(src[16]), .prescale_out(src[17]), .lens_rxd(src[22]),
        .trig_feedback(src[23]), .uart2_txd(src[24]), .od_out_o(od_out_o), .od_out_oe(od_out_oe),
        .ser_txd(ser_txd), .uart1_rxd(uart1_rxd), .cam_trigger(cam_trigger), .seq_hw_start(seq_hw_start),
        .debounce_in(debounce_in), .prescale_in(prescale_in), .lens_txd(lens_txd),
        .ploop_hw_trig(ploop_hw_trig), .uart2_rxd(uart2_rxd), .cfg_wr(cfg_wr), .cfg_dst(cfg_dst),
        .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .logic_op(logic_op),
        .config_slot_select(config_slot_select), .config_slot_load(config_slot_load),
        .config_slot_store(config_slot_store), .config_factory_load(config_factory_load), .cfg_busy(cfg_busy));

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask : tick
    // One-cycle write strobe; a gap edge between writes
    task automatic wr(input int d, input logic [CFG_W-1:0] v);
        @(posedge core_clk);
        cfg_wr <= 1'b1;
        cfg_dst <= SEL_W'(d);
        cfg_wdata <= v;
        @(posedge core_clk);
        cfg_wr <= 1'b0;
    endtask : wr
    task automatic wr_all(input logic [CFG_W-1:0] v);
        for (int d = 0; d < NUM_DST; d++) wr(d, v);
    endtask : wr_all
    // Slot pulse, optional write that busy must refuse, bounded wait
    task automatic slot(input logic l, input logic s, input logic f, input logic wb);
        @(posedge core_clk);
        config_slot_load <= l;
        config_slot_store <= s;
        config_factory_load <= f;
        config_slot_select <= 3'h2;
        @(posedge core_clk);
        config_slot_load <= 1'b0;
        config_slot_store <= 1'b0;
        config_factory_load <= 1'b0;
        if (wb) wr(DST_CAM_TRIG, 7'h00);
        tick(2);
        for (int i = 0; i < 40 && cfg_busy !== 1'b0; i++) tick(1);
        // A copy that never ends is a failure, not a silent pass
        if (cfg_busy !== 1'b0) begin
            n_fail++;
            $display("wrong value cfg_busy expected 0 seen %b", cfg_busy);
        end
    endtask : slot
    task automatic chk_line(input logic [17:0] exp);
        #1 n_checks++;
        if ((dst & VIS) !== (exp & VIS)) begin
            n_fail++;
            $display("wrong value lines expected %h seen %h", exp & VIS, dst & VIS);
        end
    endtask : chk_line
    // Read back is registered, so two edges after the index
    task automatic chk_cfg(input int d, input logic [CFG_W-1:0] exp);
        @(posedge core_clk);
        cfg_dst <= SEL_W'(d);
        tick(2);
        #1 n_checks++;
        if (cfg_rdata !== exp) begin
            n_fail++;
            $display("wrong value cfg line %0d expected %h seen %h", d, exp, cfg_rdata);
        end
    endtask : chk_cfg
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_sim

    initial begin
        tick(20000);
        n_fail++;
        end_sim();
    end

    initial begin
        logic e;
        tick(10);
        srst <= 1'b0;
        for (int d = 0; d < NUM_DST; d++) chk_cfg(d, DEFAULT_CFG);
        chk_line(18'h00000);
        // Every source except 19 (the gate) to every visible line, high then low
        for (int s = 0; s < NUM_SRC; s++) if (s != 19) begin
            wr_all({2'b00, SEL_W'(s)});
            src_set <= 25'h1 << s;
            tick(4);
            chk_line(VIS);
            tick(1);
            src_set <= ~(25'h1 << s);
            tick(4);
            chk_line(18'h00000);
        end
        // Invert, force and both, with source 0 low
        for (int m = 0; m < 4; m++) begin
            wr_all({2'(m), DEFAULT_SEL});
            src_set <= 25'h0000000;
            tick(4);
            chk_line((m == 1 || m == 2) ? VIS : 18'h00000);
        end
        // Gate on trigger pins 0 and 1, result on every visible line
        wr_all({2'b00, SRC_LOGIC});
        wr(DST_LOGIC_A, {2'b00, SRC_TRIG_IN0});
        wr(DST_LOGIC_B, {2'b00, 5'h01});
        for (int op = 0; op < 4; op++) for (int ab = 0; ab < 4; ab++) begin
            tick(1);
            logic_op <= 2'(op);
            src_set <= 25'(ab);
            e = op == 0 ? ab[0] & ab[1] : op == 1 ? ab[0] | ab[1] : op == 2 ? ab[0] ^ ab[1] : !(ab[0] & ab[1]);
            tick(8);
            chk_line(e ? VIS : 18'h00000);
        end
        // Trigger pin into pulse loops, strobe 2 back out to the other lines
        wr_all({2'b00, SRC_STROBE2});
        for (int d = DST_PLOOP0; d < DST_PLOOP0 + NUM_PLOOP; d++) wr(d, DEFAULT_CFG);
        loop_en <= 1'b1;
        src_set <= 25'h0000001;
        tick(8);
        chk_line(VIS);
        // Slot store, factory restore, load back
        wr(DST_CAM_TRIG, 7'h45);
        slot(1'b0, 1'b1, 1'b0, 1'b1);
        chk_cfg(DST_CAM_TRIG, 7'h45);
        slot(1'b0, 1'b0, 1'b1, 1'b0);
        chk_cfg(DST_CAM_TRIG, DEFAULT_CFG);
        slot(1'b1, 1'b0, 1'b0, 1'b0);
        chk_cfg(DST_CAM_TRIG, 7'h45);
        // Host-side factory reset of slot 2: factory load, then store
        slot(1'b0, 1'b0, 1'b1, 1'b0);
        slot(1'b0, 1'b1, 1'b0, 1'b0);
        wr(DST_CAM_TRIG, 7'h45);
        slot(1'b1, 1'b0, 1'b0, 1'b0);
        chk_cfg(DST_CAM_TRIG, DEFAULT_CFG);
        end_sim();
    end
endmodule : io_switch_matrix_test
